// >>> design/ccs_pkg.sv
// Constants and types for the fail-safe clock switch and reset release block
package ccs_pkg;

  // Register byte addresses
  localparam logic [3:0]  CCS_CTRL_ADDR   = 4'h0;
  localparam logic [3:0]  CCS_STAT_ADDR   = 4'h4;

  // Control register field positions
  localparam int          CCS_GO_BIT      = 0;
  localparam int          CCS_CF_BIT      = 3;
  localparam int          CCS_LOCK_BIT    = 5;
  localparam int          CCS_NEW_LSB     = 8;
  localparam int          CCS_CUR_LSB     = 12;

  // Unlock keys, low byte then high byte
  localparam logic [7:0]  CCS_LO_KEY1     = 8'h46;
  localparam logic [7:0]  CCS_LO_KEY2     = 8'h57;
  localparam logic [7:0]  CCS_HI_KEY1     = 8'h78;
  localparam logic [7:0]  CCS_HI_KEY2     = 8'h9A;

  // Oscillator groups
  localparam logic [1:0]  CCS_GRP_SEC     = 2'h0;
  localparam logic [1:0]  CCS_GRP_FRC     = 2'h1;
  localparam logic [1:0]  CCS_GRP_LOW_POWER_RC_OSC    = 2'h2;
  localparam logic [1:0]  CCS_GRP_PRI     = 2'h3;

  // Bus responses
  localparam logic [1:0]  CCS_RESP_OKAY   = 2'h0;
  localparam logic [1:0]  CCS_RESP_SLVERR = 2'h2;

  // Timing
  localparam int          CCS_CLK_PS      = 25000;
  localparam int          CCS_BIAS_NS     = 10000;
  localparam int          CCS_BIAS_CYC    = (CCS_BIAS_NS * 1000 + CCS_CLK_PS - 1) / CCS_CLK_PS;
  localparam int          CCS_POWERUP_TIMER_4_MS   = 4;
  localparam int          CCS_POWERUP_TIMER_16_MS  = 16;
  localparam int          CCS_POWERUP_TIMER_64_MS  = 64;
  localparam int          CCS_POWERUP_TIMER_4_CYC  = (CCS_POWERUP_TIMER_4_MS * 1000000) / (CCS_CLK_PS / 1000);
  localparam int          CCS_POWERUP_TIMER_16_CYC = (CCS_POWERUP_TIMER_16_MS * 1000000) / (CCS_CLK_PS / 1000);
  localparam int          CCS_POWERUP_TIMER_64_CYC = (CCS_POWERUP_TIMER_64_MS * 1000000) / (CCS_CLK_PS / 1000);
  localparam int          CCS_MASTER_CLEAR_PIN_FILT   = 8;
  localparam int          CCS_CNT_W       = 22;

  // Power-up release sequence
  typedef enum logic [1:0] {
    CCS_ST_BIAS,
    CCS_ST_POWERUP_TIMER,
    CCS_ST_Q1,
    CCS_ST_RUN
  } ccs_state_type;

endpackage

// >>> design/ccs_clock_control.sv
// Clock group switching, fail-safe monitor, protected control register and reset release
`timescale 1ns/1ps

// Notes on behaviour
// - Low-power RC on until power-up timer ends, then only if monitor, watchdog or selected.
// - With monitor on, low-power RC runs except in sleep; software watchdog bit ignored.
// - Detected oscillator failure raises a trap and moves system clock to fast RC.
// - On failure: current group becomes fast RC, fail flag set, switch-go cleared.
// - Current group value 01 means the device runs from fast RC.
// - Clock failure leaves the watchdog counting on low-power RC.
// - Timer expiring before oscillator starts traps, selects fast RC, stops original oscillator.
// - After delays, no oscillation, start-up timer pending or PLL unlocked also traps.
// - Four groups; switch only between groups; primary mode comes from configuration only.
// - Current group is read-only status; software writes new group to request a switch.
// - Power-on and brown-out load current and new group from configuration.
// - Switch-go rises as a transition begins; software clearing it aborts the transition.
// - Switch/monitor configuration 1x disables both switching and monitoring.
// - Switching disabled: configuration selects the clock, current group only mirrors it.
// - Low byte writable only right after back-to-back 0x46 then 0x57 byte writes.
// - High byte writable only right after back-to-back 0x78 then 0x9A byte writes.
// - Master-clear input filtered against short pulses; internal resets never drive it.
// - Power-on restarts the timer, holds reset and selects configured clock source.
// - Release waits a 10 us bias delay plus 0, 4, 16 or 64 ms.
// - After the delays reset releases on the next first-quarter phase edge.
// - Monitor and power-up timer off: reset leaves promptly, internal sources run at once.
// - Monitor off and no system clock: core stays frozen at the reset vector.
module ccs_clock_control
  import ccs_pkg::*;
#(
  parameter int POWERUP_TIMER_4_CYC  = CCS_POWERUP_TIMER_4_CYC,
  parameter int POWERUP_TIMER_16_CYC = CCS_POWERUP_TIMER_16_CYC,
  parameter int POWERUP_TIMER_64_CYC = CCS_POWERUP_TIMER_64_CYC
) (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  // AXI4-Lite slave
  input  wire logic [3:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [3:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  // Configuration word and events
  input  wire logic [1:0]  osc_group_cfg,
  input  wire logic [3:0]  primary_mode_cfg,
  input  wire logic [1:0]  switch_monitor_cfg,
  input  wire logic [1:0]  powerup_delay_cfg,
  input  wire logic        watchdog_cfg_enable,
  input  wire logic        sw_watchdog_enable,
  input  wire logic        por_event,
  input  wire logic        brownout_reset,
  input  wire logic        sleep_mode,
  input  wire logic        wake_event,
  input  wire logic        master_clear_pin_n,
  input  wire logic        first_quarter_phase,
  // Oscillator status
  input  wire logic [3:0]  osc_ready,
  input  wire logic        sys_clk_present,
  input  wire logic        osc_startup_timer_done,
  input  wire logic        pll_used,
  input  wire logic        pll_locked,
  // Outputs
  output logic [3:0]       osc_enable,
  output logic [1:0]       sys_clk_group,
  output logic [3:0]       primary_mode,
  output logic             low_power_rc_osc_enable,
  output logic             clock_fail_trap,
  output logic             system_reset_internal_n,
  output logic             core_run
);

  ////////////////////////////////////////////////////////////////////////
  // Configuration decode
  function automatic logic [3:0] grp_onehot(input logic [1:0] g);
    grp_onehot = 4'h1 << g;
  endfunction

  logic monitor_en;
  logic switch_en;
  logic cold_start;
  logic filt_low;

  // 1x disables both; 01 allows switching only; 00 allows both
  assign switch_en  = ~switch_monitor_cfg[1];
  assign monitor_en = ~switch_monitor_cfg[1] & ~switch_monitor_cfg[0];
  assign cold_start = ~aresetn | por_event | brownout_reset | filt_low;

  ////////////////////////////////////////////////////////////////////////
  // Master-clear noise filter: low must persist before it counts
  logic [3:0] master_clear_pin_cnt_q;
  logic       master_clear_pin_low_q;
  assign filt_low = master_clear_pin_low_q;

  // Pin is only ever an input here, so internal resets cannot pull it
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      master_clear_pin_cnt_q <= 4'h0;
      master_clear_pin_low_q <= 1'b0;
    end else if (master_clear_pin_n) begin
      master_clear_pin_cnt_q <= 4'h0;
      master_clear_pin_low_q <= 1'b0;
    end else if (master_clear_pin_cnt_q == 4'(CCS_MASTER_CLEAR_PIN_FILT - 1)) begin
      master_clear_pin_low_q <= 1'b1;
    end else begin
      master_clear_pin_cnt_q <= master_clear_pin_cnt_q + 4'h1;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Power-up sequence: bias delay, power-up delay, first-quarter edge
  ccs_state_type          st_q;
  logic [CCS_CNT_W-1:0]   cnt_q;
  logic [CCS_CNT_W-1:0]   powerup_timer_cyc;
  logic                   wake_seq_q;
  logic                   delays_done;

  always_comb begin
    unique case (powerup_delay_cfg)
      2'h0:    powerup_timer_cyc = '0;
      2'h1:    powerup_timer_cyc = CCS_CNT_W'(POWERUP_TIMER_4_CYC);
      2'h2:    powerup_timer_cyc = CCS_CNT_W'(POWERUP_TIMER_16_CYC);
      default: powerup_timer_cyc = CCS_CNT_W'(POWERUP_TIMER_64_CYC);
    endcase
  end

  assign delays_done = (st_q == CCS_ST_POWERUP_TIMER) && (cnt_q >= powerup_timer_cyc);

  // Wake from sleep reruns the timer without asserting reset
  always_ff @(posedge aclk) begin
    if (cold_start) begin
      st_q       <= CCS_ST_BIAS;
      cnt_q      <= '0;
      wake_seq_q <= 1'b0;
    end else begin
      unique case (st_q)
        CCS_ST_BIAS: begin
          cnt_q <= cnt_q + 1'b1;
          if (cnt_q == CCS_CNT_W'(CCS_BIAS_CYC - 1)) begin
            st_q  <= CCS_ST_POWERUP_TIMER;
            cnt_q <= '0;
          end
        end
        CCS_ST_POWERUP_TIMER: begin
          cnt_q <= cnt_q + 1'b1;
          if (delays_done) begin
            st_q <= wake_seq_q ? CCS_ST_RUN : CCS_ST_Q1;
          end
        end
        CCS_ST_Q1: begin
          if (first_quarter_phase) begin
            st_q <= CCS_ST_RUN;
          end
        end
        CCS_ST_RUN: begin
          if (wake_event) begin
            st_q       <= CCS_ST_POWERUP_TIMER;
            cnt_q      <= '0;
            wake_seq_q <= 1'b1;
          end
        end
      endcase
    end
  end

  // Reset release; without the monitor a missing clock parks the core at the vector
  always_ff @(posedge aclk) begin
    if (cold_start) begin
      system_reset_internal_n <= 1'b0;
      core_run                <= 1'b0;
    end else begin
      system_reset_internal_n <= (st_q == CCS_ST_RUN) || wake_seq_q;
      core_run                <= (st_q == CCS_ST_RUN) &&
                                 (sys_clk_present || monitor_en);
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // AXI4-Lite write channel capture
  logic        aw_have_q;
  logic        w_have_q;
  logic [3:0]  aw_addr_q;
  logic [31:0] w_data_q;
  logic [3:0]  w_strb_q;
  logic        wr_fire;
  logic        wr_ctrl;
  logic        lo_only;
  logic        hi_only;

  assign wr_fire = aw_have_q && w_have_q && !s_axi_bvalid;
  assign wr_ctrl = wr_fire && (aw_addr_q[3:2] == CCS_CTRL_ADDR[3:2]);
  assign lo_only = wr_ctrl && (w_strb_q == 4'h1);
  assign hi_only = wr_ctrl && (w_strb_q == 4'h2);

  // Address and data are taken in either order, one write at a time
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_have_q     <= 1'b0;
      w_have_q      <= 1'b0;
      aw_addr_q     <= 4'h0;
      w_data_q      <= 32'h0;
      w_strb_q      <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= CCS_RESP_OKAY;
    end else begin
      s_axi_awready <= !aw_have_q && !s_axi_awready && s_axi_awvalid;
      s_axi_wready  <= !w_have_q && !s_axi_wready && s_axi_wvalid;
      if (s_axi_awvalid && s_axi_awready) begin
        aw_have_q <= 1'b1;
        aw_addr_q <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_have_q <= 1'b1;
        w_data_q <= s_axi_wdata;
        w_strb_q <= s_axi_wstrb;
      end
      if (wr_fire) begin
        aw_have_q    <= 1'b0;
        w_have_q     <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= (aw_addr_q[3:2] == CCS_CTRL_ADDR[3:2]) ? CCS_RESP_OKAY : CCS_RESP_SLVERR;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Unlock sequences: 0 idle, 1 first key seen, 2 armed for one write
  logic [1:0] lo_key_q;
  logic [1:0] hi_key_q;
  logic       lo_apply;
  logic       hi_apply;

  assign lo_apply = lo_only && (lo_key_q == 2'h2);
  assign hi_apply = hi_only && (hi_key_q == 2'h2);

  // Any other bus write in between breaks the sequence
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      lo_key_q <= 2'h0;
      hi_key_q <= 2'h0;
    end else if (wr_fire) begin
      if (lo_only && lo_key_q == 2'h1 && w_data_q[7:0] == CCS_LO_KEY2) begin
        lo_key_q <= 2'h2;
      end else if (lo_only && lo_key_q != 2'h2 && w_data_q[7:0] == CCS_LO_KEY1) begin
        lo_key_q <= 2'h1;
      end else begin
        lo_key_q <= 2'h0;
      end
      if (hi_only && hi_key_q == 2'h1 && w_data_q[15:8] == CCS_HI_KEY2) begin
        hi_key_q <= 2'h2;
      end else if (hi_only && hi_key_q != 2'h2 && w_data_q[15:8] == CCS_HI_KEY1) begin
        hi_key_q <= 2'h1;
      end else begin
        hi_key_q <= 2'h0;
      end
    end
  end

  logic osc_bad;
  logic fail_det;
  logic trans_q;

  // Fast RC needs no check; a slow target clock may trip this too
  assign osc_bad  = !sys_clk_present || !osc_startup_timer_done ||
                    (pll_used && !pll_locked);
  assign fail_det = monitor_en && !sleep_mode && (st_q != CCS_ST_BIAS) &&
                    !(st_q == CCS_ST_POWERUP_TIMER && !delays_done) &&
                    (sys_clk_group != CCS_GRP_FRC) && osc_bad;

  ////////////////////////////////////////////////////////////////////////
  // Group registers and switching
  logic [1:0] cur_grp_q;
  logic [1:0] new_grp_q;
  logic       go_q;
  logic       cf_q;

  // Failure beats a same-cycle software write of the go bit
  always_ff @(posedge aclk) begin
    if (cold_start) begin
      cur_grp_q <= osc_group_cfg;
      new_grp_q <= osc_group_cfg;
      go_q      <= 1'b0;
      cf_q      <= 1'b0;
      trans_q   <= 1'b0;
    end else if (!switch_en) begin
      cur_grp_q <= osc_group_cfg;
      go_q      <= 1'b0;
      trans_q   <= 1'b0;
      if (hi_apply) begin
        new_grp_q <= w_data_q[CCS_NEW_LSB +: 2];
      end
    end else if (fail_det) begin
      cur_grp_q <= CCS_GRP_FRC;
      cf_q      <= 1'b1;
      go_q      <= 1'b0;
      trans_q   <= 1'b0;
    end else begin
      if (hi_apply) begin
        new_grp_q <= w_data_q[CCS_NEW_LSB +: 2];
      end
      if (lo_apply && !w_data_q[CCS_GO_BIT]) begin
        go_q    <= 1'b0;
        trans_q <= 1'b0;
      end else if (lo_apply && !go_q) begin
        go_q    <= 1'b1;
        trans_q <= (new_grp_q != cur_grp_q);
      end else if (go_q && (!trans_q || osc_ready[new_grp_q])) begin
        cur_grp_q <= new_grp_q;
        go_q      <= 1'b0;
        trans_q   <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Clock outputs and low-power RC enable
  logic low_power_rc_osc_on;
  logic wdt_on;

  assign wdt_on  = monitor_en ? watchdog_cfg_enable
                              : (watchdog_cfg_enable | sw_watchdog_enable);
  // Failure never touches this path, so the watchdog clock keeps running
  assign low_power_rc_osc_on = (st_q == CCS_ST_BIAS) || (st_q == CCS_ST_POWERUP_TIMER && !wake_seq_q) ||
                   (monitor_en && !sleep_mode) || wdt_on ||
                   (sys_clk_group == CCS_GRP_LOW_POWER_RC_OSC);

  always_ff @(posedge aclk) begin
    if (cold_start) begin
      sys_clk_group           <= osc_group_cfg;
      osc_enable              <= 4'h0;
      low_power_rc_osc_enable <= 1'b1;
      clock_fail_trap         <= 1'b0;
      primary_mode            <= primary_mode_cfg;
    end else begin
      sys_clk_group           <= fail_det ? CCS_GRP_FRC : cur_grp_q;
      primary_mode            <= primary_mode_cfg;
      low_power_rc_osc_enable <= low_power_rc_osc_on;
      clock_fail_trap         <= fail_det;
      // Internal sources start at once; a failed oscillator is stopped
      osc_enable              <= fail_det ? grp_onehot(CCS_GRP_FRC)
                                          : grp_onehot(cur_grp_q) |
                                            (trans_q ? grp_onehot(new_grp_q) : 4'h0);
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // AXI4-Lite read channel
  logic [31:0] ctrl_word;
  logic [31:0] stat_word;

  assign ctrl_word = (32'(cur_grp_q) << CCS_CUR_LSB) | (32'(new_grp_q) << CCS_NEW_LSB) |
                     (32'(pll_locked) << CCS_LOCK_BIT) | (32'(cf_q) << CCS_CF_BIT) | (32'(go_q) << CCS_GO_BIT);
  assign stat_word = {26'h0, trans_q, switch_en, monitor_en, low_power_rc_osc_enable,
                      (st_q == CCS_ST_RUN), system_reset_internal_n};

  // One read at a time; unmapped words read zero with an error answer
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0;
      s_axi_rresp   <= CCS_RESP_OKAY;
    end else begin
      s_axi_arready <= !s_axi_arready && !s_axi_rvalid && s_axi_arvalid;
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        if (s_axi_araddr[3:2] == CCS_CTRL_ADDR[3:2]) begin
          s_axi_rdata <= ctrl_word;
          s_axi_rresp <= CCS_RESP_OKAY;
        end else if (s_axi_araddr[3:2] == CCS_STAT_ADDR[3:2]) begin
          s_axi_rdata <= stat_word;
          s_axi_rresp <= CCS_RESP_OKAY;
        end else begin
          s_axi_rdata <= 32'h0;
          s_axi_rresp <= CCS_RESP_SLVERR;
        end
      end else if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

endmodule

// >>> bench/ccs_clock_control_checker.sv
// Assertion checker for the clock control block
`timescale 1ns/1ps
module ccs_clock_control_checker
  import ccs_pkg::*;
(
  input wire logic       aclk,
  input wire logic       aresetn,
  input wire logic [1:0] osc_group_cfg,
  input wire logic [1:0] switch_monitor_cfg,
  input wire logic       sleep_mode,
  input wire logic       first_quarter_phase,
  input wire logic       sys_clk_present,
  input wire logic       osc_startup_timer_done,
  input wire logic       pll_used,
  input wire logic       pll_locked,
  input wire logic [3:0] osc_enable,
  input wire logic [1:0] sys_clk_group,
  input wire logic       low_power_rc_osc_enable,
  input wire logic       clock_fail_trap,
  input wire logic       system_reset_internal_n,
  input wire logic       core_run
);
  logic health_bad;

  // Oscillator health as the monitor judges it
  assign health_bad = !sys_clk_present || !osc_startup_timer_done || (pll_used && !pll_locked);

  logic       early_rst;
  logic [8:0] rst_cyc_q;

  // Cycles spent in reset; the bias delay alone keeps the low-power RC on that long
  always_ff @(posedge aclk) begin
    if (!aresetn || system_reset_internal_n) begin
      rst_cyc_q <= 9'h0;
    end else if (rst_cyc_q != 9'h1FF) begin
      rst_cyc_q <= rst_cyc_q + 9'h1;
    end
  end
  assign early_rst = !system_reset_internal_n && (rst_cyc_q < 9'(CCS_BIAS_CYC));

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  a_trap_to_frc: assert property (clock_fail_trap |-> sys_clk_group == CCS_GRP_FRC && osc_enable == 4'h2)
    else $error("trap without fast RC selection");
  a_trap_cause: assert property (clock_fail_trap |-> $past(health_bad) && $past(switch_monitor_cfg) == 2'h0)
    else $error("trap without cause or with monitor off");
  a_trap_settles: assert property (clock_fail_trap |=> !clock_fail_trap && sys_clk_group == CCS_GRP_FRC)
    else $error("trap repeated or group left fast RC");
  // Quarter-phase wait comes after the timer and is not forced, so only the bias span is checked
  a_low_power_rc_osc_boot: assert property (early_rst |-> low_power_rc_osc_enable)
    else $error("low-power RC off before release");
  a_low_power_rc_osc_monitor: assert property (switch_monitor_cfg == 2'h0 && !sleep_mode |-> low_power_rc_osc_enable)
    else $error("low-power RC off with monitor on");
  a_mirror_cfg: assert property ((switch_monitor_cfg[1] && $stable(osc_group_cfg)) [*3] |-> sys_clk_group == osc_group_cfg)
    else $error("clock group not following configuration");
  a_release_q1: assert property ($rose(system_reset_internal_n) |-> $past(first_quarter_phase, 2))
    else $error("reset released off the quarter phase");
  a_frozen: assert property (switch_monitor_cfg[1] && !sys_clk_present && !$past(sys_clk_present) |-> !core_run)
    else $error("core runs without clock");
  a_reset_holds: assert property (!system_reset_internal_n |-> !core_run)
    else $error("core runs during reset");
endmodule

bind ccs_clock_control ccs_clock_control_checker u_chk (.aclk, .aresetn, .osc_group_cfg, .switch_monitor_cfg,
  .sleep_mode, .first_quarter_phase, .sys_clk_present, .osc_startup_timer_done, .pll_used, .pll_locked,
  .osc_enable, .sys_clk_group, .low_power_rc_osc_enable, .clock_fail_trap, .system_reset_internal_n, .core_run);

// >>> bench/tb.sv
// Self-checking bench for the clock control block
`timescale 1ns/1ps
module tb
  import ccs_pkg::*;
;
  logic        aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
  logic [3:0]  s_axi_awaddr, s_axi_wstrb, s_axi_araddr, osc_ready, primary_mode_cfg, osc_enable, primary_mode;
  logic [31:0] s_axi_wdata, s_axi_rdata, rdat;
  logic [1:0]  s_axi_bresp, s_axi_rresp, resp, osc_group_cfg, switch_monitor_cfg, powerup_delay_cfg, sys_clk_group;
  logic [1:0]  qc = 2'h0;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, watchdog_cfg_enable;
  logic        sw_watchdog_enable, por_event, brownout_reset, sleep_mode, wake_event, master_clear_pin_n;
  logic        first_quarter_phase, sys_clk_present, osc_startup_timer_done, pll_used, pll_locked;
  logic        low_power_rc_osc_enable, clock_fail_trap, system_reset_internal_n, core_run;
  int          err_count, cmp_count, rel;

  ccs_clock_control #(.POWERUP_TIMER_4_CYC(20), .POWERUP_TIMER_16_CYC(40), .POWERUP_TIMER_64_CYC(80)) u_dut (.aclk, .aresetn,
    .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
    .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .osc_group_cfg, .primary_mode_cfg, .switch_monitor_cfg,
    .powerup_delay_cfg, .watchdog_cfg_enable, .sw_watchdog_enable, .por_event, .brownout_reset, .sleep_mode,
    .wake_event, .master_clear_pin_n, .first_quarter_phase, .osc_ready, .sys_clk_present,
    .osc_startup_timer_done, .pll_used, .pll_locked, .osc_enable, .sys_clk_group, .primary_mode,
    .low_power_rc_osc_enable, .clock_fail_trap, .system_reset_internal_n, .core_run);

  // 40 MHz clock
  initial begin
    aclk = 1'b0;
    forever #12.5 aclk = ~aclk;
  end

  // Quarter-phase pulse every fourth cycle
  always @(posedge aclk) begin
    qc <= qc + 2'h1;
    first_quarter_phase <= (qc == 2'h3);
  end

  ////////////////////////////////////////////////////////////////////////////
  // Bus and check tasks; each bus task starts one edge later so no strobe is assigned twice
  task automatic wr(input logic [3:0] a, input logic [31:0] d, input logic [3:0] s);
    @(posedge aclk);
    s_axi_awaddr  <= a;
    s_axi_wdata   <= d;
    s_axi_wstrb   <= s;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid  <= 1'b1;
    s_axi_bready  <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
      if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1);
    resp = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask

  task automatic rd(input logic [3:0] a);
    @(posedge aclk);
    s_axi_araddr  <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready  <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1);
    rdat = s_axi_rdata;
    resp = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask

  // Single byte write to the control word, high or low lane
  task automatic wb(input bit hi, input logic [7:0] v);
    wr(CCS_CTRL_ADDR, hi ? {16'h0, v, 8'h00} : {24'h0, v}, hi ? 4'h2 : 4'h1);
  endtask

  task automatic pw(input bit hi, input logic [7:0] v);
    wb(hi, hi ? CCS_HI_KEY1 : CCS_LO_KEY1);
    wb(hi, hi ? CCS_HI_KEY2 : CCS_LO_KEY2);
    wb(hi, v);
  endtask

  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    cmp_count++;
    if (g !== e) begin
      err_count++;
      $display("mismatch at %0t: got %h expected %h", $time, g, e);
    end
  endtask

  // Cold start by reset or brownout, then count cycles to release
  task automatic cold(input bit bor, input logic [1:0] smc, input logic [1:0] pd);
    @(posedge aclk);
    aresetn            <= bor;
    brownout_reset     <= bor;
    switch_monitor_cfg <= smc;
    powerup_delay_cfg  <= pd;
    repeat (12) @(posedge aclk);
    aresetn        <= 1'b1;
    brownout_reset <= 1'b0;
    rel = 0;
    while (system_reset_internal_n !== 1'b1 && rel < 2000) begin
      @(posedge aclk);
      rel++;
    end
  endtask

  task automatic print_verdict;
    $display("errors %0d comparisons %0d", err_count, cmp_count);
    if (err_count == 0 && cmp_count > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Hang guard well above the expected run length
  initial begin
    #200000;
    err_count++;
    $display("mismatch at %0t: timeout", $time);
    print_verdict;
  end

  // Main sequence
  initial begin
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} <= 5'h0;
    {s_axi_awaddr, s_axi_wstrb, s_axi_araddr, s_axi_wdata} <= 44'h0;
    {aresetn, brownout_reset, por_event, wake_event, sleep_mode} <= 5'h0;
    {pll_used, pll_locked, watchdog_cfg_enable} <= 3'h0;
    {sw_watchdog_enable, master_clear_pin_n, sys_clk_present, osc_startup_timer_done} <= 4'hF;
    osc_group_cfg    <= CCS_GRP_PRI;
    primary_mode_cfg <= 4'hB;
    osc_ready        <= 4'hF;
    cold(1'b0, 2'h0, 2'h1);
    chk(rel >= CCS_BIAS_CYC + 20 && rel <= CCS_BIAS_CYC + 28, 1);
    chk(primary_mode, 4'hB);
    chk(osc_enable, 4'h8);
    rd(CCS_CTRL_ADDR);
    chk(rdat & 32'h3309, 32'h3300);
    rd(CCS_STAT_ADDR);
    chk(rdat & 32'h3F, 32'h1F);
    // Start-up timer drop with the monitor on
    osc_startup_timer_done <= 1'b0;
    sw_watchdog_enable     <= 1'b0;
    repeat (10) begin
      @(posedge aclk);
      if (clock_fail_trap === 1'b1) break;
    end
    chk({clock_fail_trap, sys_clk_group}, {1'b1, CCS_GRP_FRC});
    osc_startup_timer_done <= 1'b1;
    chk(low_power_rc_osc_enable, 1);
    rd(CCS_CTRL_ADDR);
    chk(rdat & 32'h3309, 32'h1308);
    pw(1'b0, 8'h01);
    rd(CCS_CTRL_ADDR);
    chk(rdat & 32'h3001, 32'h3000);
    chk(sys_clk_group, CCS_GRP_PRI);
    wb(1'b1, 8'h01);
    rd(CCS_CTRL_ADDR);
    chk(rdat[9:8], CCS_GRP_PRI);
    wr(CCS_STAT_ADDR, 32'h1, 4'hF);
    chk(resp, CCS_RESP_SLVERR);
    rd(4'h8);
    chk({rdat, resp}, {32'h0, CCS_RESP_SLVERR});
    // Switch hangs on an oscillator that never gets ready, then is aborted
    osc_ready <= 4'hB;
    pw(1'b1, 8'h12);
    pw(1'b0, 8'h01);
    rd(CCS_CTRL_ADDR);
    chk(rdat & 32'h3301, 32'h3201);
    chk(osc_enable, 4'hC);
    pw(1'b0, 8'h00);
    rd(CCS_CTRL_ADDR);
    chk(rdat & 32'h3301, 32'h3200);
    // Key pairs broken by another write
    wb(1'b0, CCS_LO_KEY1);
    wb(1'b1, 8'h00);
    wb(1'b0, CCS_LO_KEY2);
    wb(1'b0, 8'h01);
    wb(1'b1, CCS_HI_KEY1);
    wb(1'b0, 8'h00);
    wb(1'b1, CCS_HI_KEY2);
    wb(1'b1, 8'h03);
    rd(CCS_CTRL_ADDR);
    chk(rdat & 32'h3301, 32'h3200);
    // PLL out of lock with the monitor on
    pll_used <= 1'b1;
    repeat (2) @(posedge aclk);
    chk({clock_fail_trap, sys_clk_group}, {1'b1, CCS_GRP_FRC});
    pll_used <= 1'b0;
    osc_ready          <= 4'hF;
    master_clear_pin_n <= 1'b0;
    repeat (4) @(posedge aclk);
    master_clear_pin_n <= 1'b1;
    repeat (12) @(posedge aclk);
    chk(system_reset_internal_n, 1);
    // Brownout start, switching and monitor off, no power-up delay
    cold(1'b1, 2'h2, 2'h0);
    chk(rel <= CCS_BIAS_CYC + 8, 1);
    rd(CCS_CTRL_ADDR);
    chk(rdat & 32'h3300, 32'h3300);
    chk(low_power_rc_osc_enable, 0);
    sys_clk_present <= 1'b0;
    repeat (4) @(posedge aclk);
    chk(core_run, 0);
    sys_clk_present <= 1'b1;
    osc_group_cfg   <= CCS_GRP_LOW_POWER_RC_OSC;
    repeat (4) @(posedge aclk);
    chk({core_run, sys_clk_group, low_power_rc_osc_enable}, {1'b1, CCS_GRP_LOW_POWER_RC_OSC, 1'b1});
    osc_group_cfg       <= CCS_GRP_PRI;
    watchdog_cfg_enable <= 1'b1;
    repeat (4) @(posedge aclk);
    chk(low_power_rc_osc_enable, 1);
    print_verdict;
  end
endmodule
